// ### cpu_addr_jump_defines.vh
// Purpose: Shared constants of the addressing and jump unit
// Assumes: Included by bare name from each design file except the memory model
// Notes:   Operation, mode and function codes are the decoder-facing encoding
`ifndef CPU_ADDR_JUMP_DEFINES_VH
`define CPU_ADDR_JUMP_DEFINES_VH

`define PC_WIDTH        15
`define SP_RESET        8'h7F

// Operation kinds
`define OP_NOP          4'h0
`define OP_LOAD         4'h1
`define OP_EXCH         4'h2
`define OP_ALU_MEM      4'h3
`define OP_ALU_ACC      4'h4
`define OP_TEST         4'h5
`define OP_LD_B_SHORT   4'h6
`define OP_TABLE_READ   4'h7
`define OP_JUMP_TABLE   4'h8
`define OP_JUMP_REL     4'h9
`define OP_JUMP_ABS     4'hA
`define OP_JUMP_LONG    4'hB
`define OP_CALL         4'hC
`define OP_RETURN       4'hD
`define OP_VECTOR_SEL   4'hE

// Operand addressing modes
`define MODE_DIRECT     3'h0
`define MODE_INDIRECT   3'h1
`define MODE_POST_INC   3'h2
`define MODE_POST_DEC   3'h3
`define MODE_IMMEDIATE  3'h4

// Arithmetic functions
`define FN_ADD          4'h0
`define FN_ADD_CARRY    4'h1
`define FN_SUB_BORROW   4'h2
`define FN_INC          4'h3
`define FN_DEC          4'h4
`define FN_DEC_ADJUST   4'h5
`define FN_CLEAR        4'h6
`define FN_SET_CARRY    4'h7
`define FN_CLR_CARRY    4'h8

// Test functions
`define TEST_EQ         4'h0
`define TEST_NE         4'h1
`define TEST_GT         4'h2
`define TEST_CARRY      4'h3
`define TEST_NO_CARRY   4'h4

`endif

// ### arith_unit.v
// Purpose: Accumulator arithmetic datapath
// Assumes: Purely combinational, driven by the sequencer
// Notes:   Unused functions pass the accumulator and flags through
`timescale 1ns/1ns
`default_nettype none
`include "cpu_addr_jump_defines.vh"

module arith_unit (
  input  wire [3:0] fn,
  input  wire [7:0] acc,
  input  wire [7:0] operand,
  input  wire       carry_in,
  input  wire       half_in,
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        half_out
);

  reg [8:0] sum9;
  reg [4:0] low5;
  reg       lo_fix;
  reg       hi_fix;

  always @* begin
    sum9      = 9'h000;
    low5      = 5'h00;
    lo_fix    = 1'b0;
    hi_fix    = 1'b0;
    result    = acc;
    carry_out = carry_in;
    half_out  = half_in;
    case (fn) // RQ16
      `FN_ADD: begin
        result = acc + operand;
      end
      `FN_ADD_CARRY: begin
        sum9      = {1'b0, acc} + {1'b0, operand} + {8'h00, carry_in};
        low5      = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
        result    = sum9[7:0];
        carry_out = sum9[8];
        half_out  = low5[4];
      end
      `FN_SUB_BORROW: begin
        // A minus operand as A plus inverted operand plus carry
        sum9      = {1'b0, acc} + {1'b0, ~operand} + {8'h00, carry_in};
        low5      = {1'b0, acc[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, carry_in};
        result    = sum9[7:0];
        carry_out = sum9[8];
        half_out  = low5[4];
      end
      `FN_INC: begin
        result = acc + 8'h01;
      end
      `FN_DEC: begin
        result = acc - 8'h01;
      end
      `FN_DEC_ADJUST: begin
        lo_fix    = (acc[3:0] > 4'h9) | half_in;
        hi_fix    = (acc > 8'h99) | carry_in;
        result    = acc + {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
        carry_out = hi_fix;
      end
      `FN_CLEAR: begin
        result = 8'h00;
      end
      `FN_SET_CARRY: begin
        carry_out = 1'b1;
      end
      `FN_CLR_CARRY: begin
        carry_out = 1'b0;
      end
      default: begin
        result = acc;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### cpu_addressing_and_jump_unit.v
// Purpose: Operand addressing and program counter sequencing of an 8-bit core
// Assumes: Memories return read data in the cycle after the read strobe is high
// Notes:   One decoded instruction per start pulse; done pulses when it retires
`timescale 1ns/1ns
`default_nettype none
`include "cpu_addr_jump_defines.vh"

// Contract
// RQ1: Direct mode uses the instruction's address byte as the data memory location.
// RQ2: Pointer-indirect mode takes the data address from the first or second pointer as selected.
// RQ3: Post-modify mode accesses at the pointer's current value, then steps it by one.
// RQ4: Immediate mode reads the operand from program memory just after the opcode.
// RQ5: The short pointer load writes the 4-bit value to the low nibble and zeroes the high nibble.
// RQ6: The table read uses upper PC byte and accumulator as address, loads the accumulator, and resumes.
// RQ7: The PC is an upper and lower byte with the top bit unused, a 15-bit address.
// RQ8: The short relative jump adds a six-bit displacement spanning -31 to +32 to the current location.
// RQ9: Code never holds a short relative jump of plus one; a no-operation is used instead.
// RQ10: The absolute jump replaces the low 12 PC bits and keeps the upper three.
// RQ11: The long absolute jump loads all 15 PC bits from the instruction.
// RQ12: The indirect jump reads a table at upper PC byte and accumulator and loads the PC low byte.
// RQ13: Vector select reads the two-byte vector of the active interrupt and loads it into the PC.
// RQ14: A false test makes the following instruction execute as a no-operation.
// RQ15: Calls push the PC on the stack before jumping and returns pop it back.
// RQ16: Arithmetic does add, carry add, borrow subtract, inc, dec, decimal adjust, clear, set and clear carry.
// RQ17: Without a transfer of control the PC advances past every byte of the instruction.
module cpu_addressing_and_jump_unit (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        start,
  input  wire [3:0]  op_kind,
  input  wire [2:0]  addr_mode,
  input  wire        ptr_sel,
  input  wire [3:0]  alu_fn,
  input  wire [1:0]  op_len,
  input  wire [14:0] op_field,
  input  wire [14:0] vector_addr,
  input  wire [7:0]  prog_rdata,
  input  wire [7:0]  data_rdata,
  output reg  [14:0] pc,
  output reg  [7:0]  acc,
  output reg  [7:0]  b_ptr,
  output reg  [7:0]  x_ptr,
  output reg  [7:0]  sp,
  output reg         carry,
  output reg         half_carry,
  output reg         skip_next,
  output reg         busy,
  output reg         done,
  output reg  [14:0] prog_addr,
  output reg         prog_rd,
  output reg  [7:0]  data_addr,
  output reg         data_rd,
  output reg         data_wr,
  output reg  [7:0]  data_wdata
);

  localparam S_IDLE = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_TAKE = 3'h2;
  localparam S_PUSH = 3'h3;
  localparam S_FIN  = 3'h4;

  reg  [2:0]  state;
  reg         step;
  reg  [3:0]  kind_q;
  reg  [2:0]  mode_q;
  reg         sel_q;
  reg  [3:0]  fn_q;
  reg  [14:0] next_pc;
  reg  [14:0] ret_pc;
  reg  [6:0]  hold_hi;
  reg  [14:0] call_target;

  wire [14:0] seq_pc     = pc + {13'h0000, op_len}; // RQ17
  wire [14:0] rel_offset = {{9{op_field[5]}}, op_field[5:0]} + 15'h0001;
  wire [7:0]  ptr_val    = ptr_sel ? x_ptr : b_ptr; // RQ2
  wire [7:0]  opnd_addr  = (addr_mode == `MODE_DIRECT) ? op_field[7:0] : ptr_val; // RQ1
  wire        uses_opnd  = (op_kind == `OP_LOAD) || (op_kind == `OP_EXCH) ||
                           (op_kind == `OP_ALU_MEM) || (op_kind == `OP_TEST);
  // Vector bytes come from program memory whatever mode the decoder handed in
  wire        rd_prog    = (kind_q == `OP_VECTOR_SEL) || ((kind_q != `OP_RETURN) && (mode_q == `MODE_IMMEDIATE));
  wire [7:0]  rd_value   = rd_prog ? prog_rdata : data_rdata;
  wire [7:0]  alu_opnd   = (state == S_TAKE) ? rd_value : 8'h00;
  wire [3:0]  alu_sel    = (state == S_IDLE) ? alu_fn : fn_q;

  wire [7:0]  alu_result;
  wire        alu_carry;
  wire        alu_half;

  arith_unit u_arith (
    .fn        (alu_sel),
    .acc       (acc),
    .operand   (alu_opnd),
    .carry_in  (carry),
    .half_in   (half_carry),
    .result    (alu_result),
    .carry_out (alu_carry),
    .half_out  (alu_half)
  );

  reg test_true;

  always @* begin
    test_true = 1'b1;
    case (fn_q)
      `TEST_EQ:       test_true = (acc == rd_value);
      `TEST_NE:       test_true = (acc != rd_value);
      `TEST_GT:       test_true = (acc > rd_value);
      `TEST_CARRY:    test_true = carry;
      `TEST_NO_CARRY: test_true = ~carry;
      default:        test_true = 1'b1;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state      <= S_IDLE;
      step       <= 1'b0;
      kind_q     <= `OP_NOP;
      mode_q     <= `MODE_DIRECT;
      sel_q      <= 1'b0;
      fn_q       <= 4'h0;
      next_pc    <= 15'h0000;
      ret_pc     <= 15'h0000;
      hold_hi    <= 7'h00;
      pc         <= 15'h0000;
      acc        <= 8'h00;
      b_ptr      <= 8'h00;
      x_ptr      <= 8'h00;
      sp         <= `SP_RESET;
      carry      <= 1'b0;
      half_carry <= 1'b0;
      skip_next  <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      prog_addr  <= 15'h0000;
      prog_rd    <= 1'b0;
      data_addr  <= 8'h00;
      data_rd    <= 1'b0;
      data_wr    <= 1'b0;
      data_wdata <= 8'h00;
    end else begin
      prog_rd <= 1'b0;
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      done    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            kind_q  <= op_kind;
            mode_q  <= addr_mode;
            sel_q   <= ptr_sel;
            fn_q    <= alu_fn;
            step    <= 1'b0;
            next_pc <= seq_pc;
            ret_pc  <= seq_pc;
            busy    <= 1'b1;
            state   <= S_FIN;
            if (skip_next) begin
              // Skipped instruction only moves the PC past itself
              skip_next <= 1'b0; // RQ14
              kind_q    <= `OP_NOP;
            end else if (uses_opnd) begin
              state <= S_WAIT;
              if (addr_mode == `MODE_IMMEDIATE) begin
                prog_addr <= pc + 15'h0001; // RQ4
                prog_rd   <= 1'b1;
              end else begin
                data_addr <= opnd_addr; // RQ1 RQ2 RQ3
                data_rd   <= 1'b1;
              end
            end else begin
              case (op_kind)
                `OP_ALU_ACC: begin
                  acc        <= alu_result; // RQ16
                  carry      <= alu_carry;
                  half_carry <= alu_half;
                end
                `OP_LD_B_SHORT: b_ptr <= {4'h0, op_field[3:0]}; // RQ5
                `OP_TABLE_READ, `OP_JUMP_TABLE: begin
                  prog_addr <= {pc[14:8], acc}; // RQ6 RQ12 RQ7
                  prog_rd   <= 1'b1;
                  state     <= S_WAIT;
                end
                `OP_JUMP_REL:  next_pc <= pc + rel_offset; // RQ8
                `OP_JUMP_ABS:  next_pc <= {pc[14:12], op_field[11:0]}; // RQ10
                `OP_JUMP_LONG: next_pc <= op_field; // RQ11
                `OP_CALL: begin
                  data_addr  <= sp; // RQ15
                  data_wdata <= seq_pc[7:0];
                  data_wr    <= 1'b1;
                  sp         <= sp - 8'h01;
                  state      <= S_PUSH;
                end
                `OP_RETURN: begin
                  data_addr <= sp + 8'h01; // RQ15
                  data_rd   <= 1'b1;
                  sp        <= sp + 8'h01;
                  state     <= S_WAIT;
                end
                `OP_VECTOR_SEL: begin
                  prog_addr <= vector_addr; // RQ13
                  prog_rd   <= 1'b1;
                  state     <= S_WAIT;
                end
                default: state <= S_FIN;
              endcase
            end
          end
        end
        S_WAIT: state <= S_TAKE;
        S_TAKE: begin
          state <= S_FIN;
          case (kind_q)
            `OP_LOAD: acc <= rd_value;
            `OP_EXCH: begin
              acc        <= rd_value;
              data_wdata <= acc;
              data_wr    <= 1'b1;
            end
            `OP_ALU_MEM: begin
              acc        <= alu_result; // RQ16
              carry      <= alu_carry;
              half_carry <= alu_half;
            end
            `OP_TEST:       skip_next <= ~test_true; // RQ14
            `OP_TABLE_READ: acc <= prog_rdata; // RQ6
            `OP_JUMP_TABLE: next_pc <= {pc[14:8], prog_rdata}; // RQ12
            `OP_RETURN, `OP_VECTOR_SEL: begin
              if (!step) begin
                hold_hi <= rd_value[6:0];
                step    <= 1'b1;
                state   <= S_WAIT;
                if (kind_q == `OP_RETURN) begin
                  data_addr <= sp + 8'h01; // RQ15
                  data_rd   <= 1'b1;
                  sp        <= sp + 8'h01;
                end else begin
                  prog_addr <= prog_addr + 15'h0001; // RQ13
                  prog_rd   <= 1'b1;
                end
              end else begin
                next_pc <= {hold_hi, rd_value}; // RQ13 RQ15
              end
            end
            default: state <= S_FIN;
          endcase
        end
        S_PUSH: begin
          data_addr  <= sp; // RQ15
          data_wdata <= {1'b0, ret_pc[14:8]};
          data_wr    <= 1'b1;
          sp         <= sp - 8'h01;
          next_pc    <= call_target; // RQ15
          state      <= S_FIN;
        end
        S_FIN: begin
          pc    <= next_pc; // RQ17 RQ7
          busy  <= 1'b0;
          done  <= 1'b1;
          state <= S_IDLE;
          if (mode_q == `MODE_POST_INC || mode_q == `MODE_POST_DEC) begin
            if (kind_q == `OP_LOAD || kind_q == `OP_EXCH || kind_q == `OP_ALU_MEM || kind_q == `OP_TEST) begin
              if (sel_q) begin
                x_ptr <= (mode_q == `MODE_POST_INC) ? x_ptr + 8'h01 : x_ptr - 8'h01; // RQ3
              end else begin
                b_ptr <= (mode_q == `MODE_POST_INC) ? b_ptr + 8'h01 : b_ptr - 8'h01; // RQ3
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      call_target <= 15'h0000;
    end else if (state == S_IDLE && start) begin
      call_target <= op_field;
    end
  end

endmodule
`default_nettype wire

// ### prog_data_memory.sv
// Purpose: Program and data memory seen by the addressing and jump unit
// Assumes: Read data is returned in the cycle after the read strobe
// Notes:   Between reads the data lines toggle, so a stale byte never passes
`timescale 1ns/1ns
`default_nettype none
module prog_data_memory (
  input  wire logic        core_clk,
  input  wire logic [14:0] prog_addr,
  input  wire logic        prog_rd,
  input  wire logic [7:0]  data_addr,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output var  logic [7:0]  prog_rdata,
  output var  logic [7:0]  data_rdata
);
  logic [7:0] dmem [0:255];
  integer     i;
  function automatic [7:0] pbyte(input [14:0] a);
    pbyte = a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      dmem[i] = i[7:0] ^ 8'h5A;
    end
  end
  always @(posedge core_clk) begin
    prog_rdata <= prog_rd ? pbyte(prog_addr) : ~prog_rdata;
    data_rdata <= data_rd ? dmem[data_addr] : ~data_rdata;
    if (data_wr) begin
      dmem[data_addr] <= data_wdata;
    end
  end
endmodule
`default_nettype wire

// ### cpu_addr_jump_sva.sv
// Purpose: Port-level checks of the addressing and jump unit
// Assumes: One instruction in flight; state snapshot taken when start is accepted
// Notes:   Bound to the unit below the module
`timescale 1ns/1ns
`default_nettype none
`include "cpu_addr_jump_defines.vh"
module cpu_addr_jump_sva (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [3:0]  op_kind,
  input wire logic [2:0]  addr_mode,
  input wire logic        ptr_sel,
  input wire logic [1:0]  op_len,
  input wire logic [14:0] op_field,
  input wire logic [14:0] pc,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  b_ptr,
  input wire logic [7:0]  x_ptr,
  input wire logic [7:0]  sp,
  input wire logic        skip_next,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [14:0] prog_addr,
  input wire logic        prog_rd,
  input wire logic [7:0]  data_addr,
  input wire logic        data_rd,
  input wire logic        data_wr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [14:0] pc0, fld0;
  logic [7:0]  acc0, b0, x0, sp0;
  logic [3:0]  k0;
  logic [2:0]  m0;
  logic [1:0]  n0;
  logic        p0, sk0;
  wire         take = start && !busy;
  wire         run = done && !sk0;
  wire         go = take && !skip_next;
  // State an instruction started from
  always @(posedge core_clk) begin
    if (reset) begin
      k0 <= `OP_NOP;
      sk0 <= 1'b0;
    end else if (take) begin
      {pc0, fld0, acc0, b0, x0, sp0} <= {pc, op_field, acc, b_ptr, x_ptr, sp};
      {k0, m0, n0, p0, sk0} <= {op_kind, addr_mode, op_len, ptr_sel, skip_next};
    end
  end
  direct_addr_a: assert property (go && op_kind == `OP_LOAD && addr_mode == `MODE_DIRECT
    |=> data_rd && data_addr == fld0[7:0]) else $error("direct address wrong");
  ptr_addr_a: assert property (go && op_kind inside {`OP_LOAD, `OP_EXCH} && addr_mode inside
    {`MODE_INDIRECT, `MODE_POST_INC, `MODE_POST_DEC} |=> data_rd && data_addr == (p0 ? x0 : b0))
    else $error("pointer address wrong");
  post_step_a: assert property (run && k0 inside {`OP_LOAD, `OP_EXCH} && m0 inside
    {`MODE_POST_INC, `MODE_POST_DEC} |-> (p0 ? x_ptr : b_ptr) == (p0 ? x0 : b0)
    + ((m0 == `MODE_POST_INC) ? 8'h01 : 8'hFF)) else $error("pointer step wrong");
  imm_fetch_a: assert property (go && op_kind == `OP_LOAD && addr_mode == `MODE_IMMEDIATE
    |=> prog_rd && !data_rd && prog_addr == pc0 + 15'h0001) else $error("immediate fetch wrong");
  short_load_a: assert property (run && k0 == `OP_LD_B_SHORT |-> b_ptr == {4'h0, fld0[3:0]})
    else $error("short load wrong");
  table_addr_a: assert property (go && op_kind inside {`OP_TABLE_READ, `OP_JUMP_TABLE}
    |=> prog_rd && prog_addr == {pc0[14:8], acc0}) else $error("table address wrong");
  rel_jump_a: assert property (take && op_kind == `OP_JUMP_REL && !skip_next |-> ##1 busy
    ##1 done && pc == pc0 + {{9{fld0[5]}}, fld0[5:0]} + 15'h0001) else $error("relative jump wrong");
  abs_jump_a: assert property (run && k0 == `OP_JUMP_ABS |-> pc == {pc0[14:12], fld0[11:0]})
    else $error("absolute jump wrong");
  long_jump_a: assert property (run && k0 == `OP_JUMP_LONG |-> pc == fld0) else $error("long jump wrong");
  call_push_a: assert property (go && op_kind == `OP_CALL |=> data_wr && data_addr == sp0
    ##1 data_wr && data_addr == sp0 - 8'h01 ##1 done && pc == fld0 && sp == sp0 - 8'h02)
    else $error("call push wrong");
  skip_nop_a: assert property (done && sk0 |-> pc == pc0 + {13'h0000, n0} && acc == acc0
    && b_ptr == b0 && x_ptr == x0 && sp == sp0) else $error("skipped instruction changed state");
  advance_a: assert property (run && k0 inside {`OP_NOP, `OP_LOAD, `OP_EXCH, `OP_ALU_ACC, `OP_TEST,
    `OP_LD_B_SHORT, `OP_TABLE_READ} |-> pc == pc0 + {13'h0000, n0}) else $error("pc advance wrong");
  cover property (run && k0 == `OP_CALL);
  cover property (run && k0 == `OP_VECTOR_SEL);
  cover property (done && sk0);
endmodule
bind cpu_addressing_and_jump_unit cpu_addr_jump_sva chk (
  .core_clk(core_clk), .reset(reset), .start(start), .op_kind(op_kind), .addr_mode(addr_mode),
  .ptr_sel(ptr_sel), .op_len(op_len), .op_field(op_field), .pc(pc), .acc(acc), .b_ptr(b_ptr),
  .x_ptr(x_ptr), .sp(sp), .skip_next(skip_next), .busy(busy), .done(done), .prog_addr(prog_addr),
  .prog_rd(prog_rd), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr));
`default_nettype wire

// ### cpu_addressing_and_jump_unit_tb_top.sv
// Purpose: Self-checking bench of the addressing and jump unit
// Assumes: Memory model answers every read one cycle late
// Notes:   Expected pc and accumulator are tracked in the bench
`timescale 1ns/1ns
`default_nettype none
`include "cpu_addr_jump_defines.vh"
module cpu_addressing_and_jump_unit_tb_top;
  logic        core_clk = 1'b0, reset = 1'b1, start = 1'b0, ptr_sel = 1'b0;
  logic [3:0]  op_kind = 4'h0, alu_fn = 4'h0;
  logic [2:0]  addr_mode = 3'h0;
  logic [1:0]  op_len = 2'h1;
  logic [14:0] op_field = 15'h0000, vector_addr = 15'h0000, epc = 15'h0000;
  logic [7:0]  eacc = 8'h00;
  wire  [14:0] pc, prog_addr;
  wire  [7:0]  acc, b_ptr, x_ptr, sp, data_addr, data_wdata, prog_rdata, data_rdata;
  wire         carry, half_carry, skip_next, busy, done, prog_rd, data_rd, data_wr;
  integer      mismatches = 0, num_checks = 0, cyc = 0;
  cpu_addressing_and_jump_unit dut (
    .core_clk(core_clk), .reset(reset), .start(start), .op_kind(op_kind), .addr_mode(addr_mode),
    .ptr_sel(ptr_sel), .alu_fn(alu_fn), .op_len(op_len), .op_field(op_field), .vector_addr(vector_addr),
    .prog_rdata(prog_rdata), .data_rdata(data_rdata), .pc(pc), .acc(acc), .b_ptr(b_ptr), .x_ptr(x_ptr),
    .sp(sp), .carry(carry), .half_carry(half_carry), .skip_next(skip_next), .busy(busy), .done(done),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata));
  prog_data_memory mem (
    .core_clk(core_clk), .prog_addr(prog_addr), .prog_rd(prog_rd), .data_addr(data_addr), .data_rd(data_rd),
    .data_wr(data_wr), .data_wdata(data_wdata), .prog_rdata(prog_rdata), .data_rdata(data_rdata));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  function automatic [7:0] pb(input [14:0] a);
    pb = a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  task automatic results;
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input [14:0] e, input [14:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One instruction: hand in, wait for retire, compare the new pc
  task automatic op(input [3:0] k, input [1:0] n, input [14:0] npc, input [14:0] fld = 15'h0000,
                    input [2:0] m = 3'h0, input p = 1'b0, input [3:0] f = 4'h0);
    integer w;
    @(posedge core_clk);
    {start, op_kind, op_len, op_field, addr_mode, ptr_sel, alu_fn} <= {1'b1, k, n, fld, m, p, f};
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    w = 0;
    while (done !== 1'b1 && w < 12) begin
      @(posedge core_clk);
      #1;
      w = w + 1;
    end
    chk("done", 15'h0001, {14'h0000, done});
    chk("pc", npc, pc);
    epc = npc;
  endtask
  task automatic t_load;
    chk("sp reset", 15'h007F, sp);
    op(`OP_LOAD, 2'h2, epc + 15'h0002, 15'h0005);
    chk("acc direct", 15'h005F, acc);
    eacc = pb(epc + 15'h0001);
    op(`OP_LOAD, 2'h2, epc + 15'h0002, 15'h0000, `MODE_IMMEDIATE);
    chk("acc immediate", eacc, acc);
  endtask
  task automatic t_ptr;
    op(`OP_EXCH, 2'h1, epc + 15'h0001, 15'h0000, `MODE_POST_DEC);
    chk("acc swap b", 15'h005A, acc);
    chk("mem swap b", eacc, mem.dmem[0]);
    chk("b post dec", 15'h00FF, b_ptr);
    op(`OP_LD_B_SHORT, 2'h1, epc + 15'h0001, 15'h7FF7);
    chk("b short", 15'h0007, b_ptr);
    op(`OP_EXCH, 2'h1, epc + 15'h0001, 15'h0000, `MODE_POST_INC, 1'b1);
    chk("acc swap x", eacc, acc);
    chk("x post inc", 15'h0001, x_ptr);
    op(`OP_LOAD, 2'h1, epc + 15'h0001, 15'h0000, `MODE_INDIRECT);
    chk("acc via b", 15'h005D, acc);
    chk("b kept", 15'h0007, b_ptr);
    eacc = 8'h5D;
  endtask
  task automatic t_table;
    // A non-zero upper byte makes the table byte differ from the accumulator
    op(`OP_JUMP_LONG, 2'h3, 15'h0B40, 15'h0B40);
    eacc = pb({epc[14:8], eacc});
    op(`OP_TABLE_READ, 2'h1, epc + 15'h0001);
    chk("acc table", eacc, acc);
    op(`OP_JUMP_TABLE, 2'h1, {epc[14:8], pb({epc[14:8], eacc})});
    chk("acc after jump", eacc, acc);
  endtask
  task automatic t_jumps;
    logic [5:0] codes [0:2];
    integer     j;
    codes = '{6'h09, 6'h1F, 6'h20};
    op(`OP_JUMP_LONG, 2'h3, 15'h4C77, 15'h4C77);
    op(`OP_JUMP_ABS, 2'h2, 15'h4125, 15'h0125);
    // Code zero would be a jump of plus one, never handed in
    for (j = 0; j < 3; j = j + 1) begin
      op(`OP_JUMP_REL, 2'h1, epc + {{9{codes[j][5]}}, codes[j]} + 15'h0001, {9'h000, codes[j]});
    end
  endtask
  task automatic t_call;
    logic [14:0] ret;
    ret = epc + 15'h0003;
    op(`OP_CALL, 2'h3, 15'h1234, 15'h1234);
    chk("stack low", ret[7:0], mem.dmem[8'h7F]);
    chk("stack high", {1'b0, ret[14:8]}, mem.dmem[8'h7E]);
    chk("sp pushed", 15'h007D, sp);
    op(`OP_RETURN, 2'h1, ret);
    chk("sp popped", 15'h007F, sp);
  endtask
  task automatic t_vis;
    logic [15:0] v;
    v = {pb(15'h0234), pb(15'h0235)};
    @(posedge core_clk);
    vector_addr <= 15'h0234;
    op(`OP_VECTOR_SEL, 2'h1, v[14:0]);
  endtask
  task automatic alu(input [3:0] f, input [7:0] ea, input ec, input imm = 1'b0);
    op(imm ? `OP_ALU_MEM : `OP_ALU_ACC, imm ? 2'h2 : 2'h1, epc + {13'h0000, imm, ~imm}, 15'h0000,
       imm ? `MODE_IMMEDIATE : `MODE_DIRECT, 1'b0, f);
    chk("acc alu", ea, acc);
    chk("carry", {14'h0000, ec}, {14'h0000, carry});
  endtask
  task automatic t_alu_skip;
    alu(`FN_CLEAR, 8'h00, 1'b0);
    alu(`FN_INC, 8'h01, 1'b0);
    alu(`FN_DEC, 8'h00, 1'b0);
    alu(`FN_DEC, 8'hFF, 1'b0);
    alu(`FN_SET_CARRY, 8'hFF, 1'b1);
    op(`OP_TEST, 2'h2, epc + 15'h0002, 15'h0000, `MODE_IMMEDIATE, 1'b0, `TEST_NO_CARRY);
    chk("skip set", 15'h0001, {14'h0000, skip_next});
    op(`OP_LOAD, 2'h2, epc + 15'h0002, 15'h0000, `MODE_IMMEDIATE);
    chk("acc kept", 15'h00FF, acc);
    chk("skip clear", 15'h0000, {14'h0000, skip_next});
    alu(`FN_CLR_CARRY, 8'hFF, 1'b0);
    // Fixed pc so the immediate bytes are known: 10, 12, then 17
    op(`OP_JUMP_LONG, 2'h3, 15'h0110, 15'h0110);
    alu(`FN_ADD, 8'h0F, 1'b0, 1'b1);
    alu(`FN_ADD_CARRY, 8'h21, 1'b0, 1'b1);
    chk("half carry", 15'h0001, {14'h0000, half_carry});
    alu(`FN_DEC_ADJUST, 8'h27, 1'b0);
    alu(`FN_SUB_BORROW, 8'h0F, 1'b1, 1'b1);
    op(`OP_TEST, 2'h2, epc + 15'h0002, 15'h0000, `MODE_IMMEDIATE, 1'b0, `TEST_CARRY);
    chk("skip not set", 15'h0000, {14'h0000, skip_next});
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_load;
    t_ptr;
    t_table;
    t_jumps;
    t_call;
    t_vis;
    t_alu_skip;
    results;
  end
endmodule
`default_nettype wire
